// ==== rtl/temp_sensor_i2c.sv ====
/*
 * Two-wire slave side of the temperature sensor: pointer register,
 * temperature and limit byte pairs, and the two open-drain alerts.
 * Assumes temp_word comes from the measuring logic on sys_clk and the
 * serial clock is far slower than sys_clk (edges are oversampled).
 */
`timescale 1ns/1ps

module temp_sensor_i2c (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [15:0] temp_word,
  input wire logic range_active_high,
  input wire logic crit_active_high,
  output logic range_alert_out,
  output logic range_alert_oe,
  output logic critical_alert_out,
  output logic critical_alert_oe
);

  // ----------------------------------------------------------------
  // Line conditioning
  // ----------------------------------------------------------------
  logic scl_rise, scl_fall, start_det, stop_det, sda_level;

  i2c_line_sync u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det),
    .sda_level(sda_level)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Pointer values that start an auto-advancing byte pair (the MSB pointers only)
  function automatic logic is_pair(input logic [7:0] p);
    is_pair = (p == temp_sensor_pkg::PTR_TEMP_MSB) || (p == temp_sensor_pkg::PTR_HIGH_MSB) ||
              (p == temp_sensor_pkg::PTR_LOW_MSB) || (p == temp_sensor_pkg::PTR_CRIT_MSB);
  endfunction : is_pair

  // Next pointer after one byte has been moved
  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    next_ptr = is_pair(p) ? p + 8'h01 : p;
  endfunction : next_ptr

  // ----------------------------------------------------------------
  // Transfer state
  // ----------------------------------------------------------------
  temp_sensor_pkg::xfer_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] ptr_q, ptr_d;
  logic read_q, read_d;
  logic first_q, first_d;
  logic ptr_written_q, ptr_written_d;
  logic busy_q, busy_d;
  logic rep_q, rep_d;
  logic nack_q, nack_d;
  logic drive_q, drive_d;
  logic [15:0] high_q, high_d, low_q, low_d, crit_q, crit_d;
  logic addr_hit;

  assign addr_hit = (shift_q[7:1] == temp_sensor_pkg::SLAVE_ADDR);

  // Register read mux; unimplemented pointers read as zero
  function automatic logic [7:0] reg_byte(input logic [7:0] p, input logic [15:0] t,
                                          input logic [15:0] h, input logic [15:0] l,
                                          input logic [15:0] c);
    case (p)
      temp_sensor_pkg::PTR_TEMP_MSB: reg_byte = t[15:8];
      temp_sensor_pkg::PTR_TEMP_LSB: reg_byte = t[7:0];
      temp_sensor_pkg::PTR_HIGH_MSB: reg_byte = h[15:8];
      temp_sensor_pkg::PTR_HIGH_LSB: reg_byte = h[7:0];
      temp_sensor_pkg::PTR_LOW_MSB: reg_byte = l[15:8];
      temp_sensor_pkg::PTR_LOW_LSB: reg_byte = l[7:0];
      temp_sensor_pkg::PTR_CRIT_MSB: reg_byte = c[15:8];
      temp_sensor_pkg::PTR_CRIT_LSB: reg_byte = c[7:0];
      default: reg_byte = 8'h00;
    endcase
  endfunction : reg_byte

  // Byte that the current pointer selects, loaded at the start of each read byte
  logic [7:0] rd_byte;

  assign rd_byte = reg_byte(ptr_q, temp_word, high_q, low_q, crit_q);

  // Next-state logic of the byte engine
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    read_d = read_q;
    first_d = first_q;
    ptr_written_d = ptr_written_q;
    busy_d = busy_q;
    rep_d = rep_q;
    nack_d = nack_q;
    drive_d = drive_q;
    high_d = high_q;
    low_d = low_q;
    crit_d = crit_q;
    if (stop_det) begin
      state_d = temp_sensor_pkg::ST_IDLE;
      busy_d = 1'b0;
      drive_d = 1'b0;
    end else if (start_det) begin
      state_d = temp_sensor_pkg::ST_ADDR;
      rep_d = busy_q;
      busy_d = 1'b1;
      cnt_d = 4'h0;
      drive_d = 1'b0;
    end else begin
      case (state_q)
        temp_sensor_pkg::ST_IDLE: begin
          drive_d = 1'b0;
        end
        temp_sensor_pkg::ST_ADDR: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_level};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == temp_sensor_pkg::BYTE_BITS) begin
            if (addr_hit) begin
              state_d = temp_sensor_pkg::ST_ADDR_ACK;
              drive_d = 1'b1;
              read_d = shift_q[0];
              first_d = 1'b1;
              if (shift_q[0]) begin
                ptr_written_d = 1'b0;
                if (ptr_written_q && !rep_q) begin
                  ptr_d = temp_sensor_pkg::PTR_RESET;
                end
              end
            end else begin
              state_d = temp_sensor_pkg::ST_IDLE;
            end
          end
        end
        temp_sensor_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (read_q) begin
              state_d = temp_sensor_pkg::ST_READ;
              tx_d = rd_byte;
              drive_d = ~rd_byte[7];
            end else begin
              state_d = temp_sensor_pkg::ST_WRITE;
              drive_d = 1'b0;
            end
          end
        end
        temp_sensor_pkg::ST_WRITE: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_level};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == temp_sensor_pkg::BYTE_BITS) begin
            state_d = temp_sensor_pkg::ST_WRITE_ACK;
            drive_d = 1'b1;
            first_d = 1'b0;
            if (first_q) begin
              ptr_d = shift_q;
              ptr_written_d = 1'b1;
            end else begin
              case (ptr_q)
                temp_sensor_pkg::PTR_HIGH_MSB: high_d[15:8] = shift_q;
                temp_sensor_pkg::PTR_HIGH_LSB: high_d[7:0] = shift_q;
                temp_sensor_pkg::PTR_LOW_MSB: low_d[15:8] = shift_q;
                temp_sensor_pkg::PTR_LOW_LSB: low_d[7:0] = shift_q;
                temp_sensor_pkg::PTR_CRIT_MSB: crit_d[15:8] = shift_q;
                temp_sensor_pkg::PTR_CRIT_LSB: crit_d[7:0] = shift_q;
                default: ;
              endcase
              ptr_d = next_ptr(ptr_q);
            end
          end
        end
        temp_sensor_pkg::ST_WRITE_ACK: begin
          if (scl_fall) begin
            state_d = temp_sensor_pkg::ST_WRITE;
            drive_d = 1'b0;
            cnt_d = 4'h0;
          end
        end
        temp_sensor_pkg::ST_READ: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == temp_sensor_pkg::BYTE_BITS) begin
              state_d = temp_sensor_pkg::ST_READ_ACK;
              drive_d = 1'b0;
              ptr_d = next_ptr(ptr_q);
            end else begin
              drive_d = ~tx_q[3'h7 - cnt_q[2:0]];
            end
          end
        end
        temp_sensor_pkg::ST_READ_ACK: begin
          if (scl_rise) begin
            nack_d = sda_level;
          end else if (scl_fall) begin
            cnt_d = 4'h0;
            if (nack_q) begin
              state_d = temp_sensor_pkg::ST_IDLE;
            end else begin
              state_d = temp_sensor_pkg::ST_READ;
              tx_d = rd_byte;
              drive_d = ~rd_byte[7];
            end
          end
        end
        default: begin
          state_d = temp_sensor_pkg::ST_IDLE;
          drive_d = 1'b0;
        end
      endcase
    end
  end

  // Registers of the byte engine; pointer starts on temperature MSB
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= temp_sensor_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= temp_sensor_pkg::PTR_RESET;
      read_q <= 1'b0;
      first_q <= 1'b0;
      ptr_written_q <= 1'b0;
      busy_q <= 1'b0;
      rep_q <= 1'b0;
      nack_q <= 1'b0;
      drive_q <= 1'b0;
      high_q <= temp_sensor_pkg::HIGH_LIMIT_RESET;
      low_q <= temp_sensor_pkg::LOW_LIMIT_RESET;
      crit_q <= temp_sensor_pkg::CRIT_LIMIT_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      read_q <= read_d;
      first_q <= first_d;
      ptr_written_q <= ptr_written_d;
      busy_q <= busy_d;
      rep_q <= rep_d;
      nack_q <= nack_d;
      drive_q <= drive_d;
      high_q <= high_d;
      low_q <= low_d;
      crit_q <= crit_d;
    end
  end

  // Data line is open-drain: pull low only
  assign sda_out = 1'b0;
  assign sda_oe = drive_q;

  // ----------------------------------------------------------------
  // Alert comparators
  // ----------------------------------------------------------------
  logic range_q, range_d, crit_hit_q, crit_hit_d;

  // Signed window and critical compares
  always_comb begin
    range_d = ($signed(temp_word) > $signed(high_q)) ||
              ($signed(temp_word) < $signed(low_q));
    crit_hit_d = $signed(temp_word) > $signed(crit_q);
  end

  // Registered alert conditions
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      range_q <= 1'b0;
      crit_hit_q <= 1'b0;
    end else begin
      range_q <= range_d;
      crit_hit_q <= crit_hit_d;
    end
  end

  // Open-drain: pull low when the pin level must be low
  assign range_alert_out = 1'b0;
  assign range_alert_oe = ~(range_q ? range_active_high : ~range_active_high);
  assign critical_alert_out = 1'b0;
  assign critical_alert_oe = ~(crit_hit_q ? crit_active_high : ~crit_active_high);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_addr_done;
    scl_fall && !start_det && !stop_det && state_q == temp_sensor_pkg::ST_ADDR &&
      cnt_q == temp_sensor_pkg::BYTE_BITS;
  endsequence

  a_addr_match: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == temp_sensor_pkg::ST_ADDR_ACK |-> shift_q[7:1] == temp_sensor_pkg::SLAVE_ADDR)
    else $error("ack state entered for foreign address");

  a_addr_ack_drive: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_addr_done ##0 addr_hit |=> sda_oe && read_q == $past(shift_q[0]))
    else $error("address not acknowledged");

  a_ptr_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_addr_done ##0 (addr_hit && shift_q[0] && ptr_written_q && !rep_q)
    |=> ptr_q == temp_sensor_pkg::PTR_RESET)
    else $error("pointer not cleared on plain read");

  a_ptr_load: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (scl_fall && !start_det && !stop_det && state_q == temp_sensor_pkg::ST_WRITE &&
     cnt_q == temp_sensor_pkg::BYTE_BITS && first_q) |=> ptr_q == $past(shift_q) && sda_oe)
    else $error("pointer byte not loaded");

  a_rd_incr: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (scl_fall && !start_det && !stop_det && state_q == temp_sensor_pkg::ST_READ &&
     cnt_q == temp_sensor_pkg::BYTE_BITS && is_pair(ptr_q)) |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance in pair");

  a_msb_first: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (scl_fall && !start_det && !stop_det && state_q == temp_sensor_pkg::ST_ADDR_ACK &&
     read_q && ptr_q == temp_sensor_pkg::PTR_TEMP_MSB) |=> tx_q == $past(temp_word[15:8]))
    else $error("temperature MSB not sent first");

  a_range_alert: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($signed(temp_word) > $signed(high_q) || $signed(temp_word) < $signed(low_q))
    ##1 $stable(high_q) && $stable(low_q) |-> range_alert_oe == !range_active_high)
    else $error("range alert not at active level");

  a_crit_alert: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $signed(temp_word) <= $signed(crit_q) ##1 $stable(crit_q)
    |-> critical_alert_oe == crit_active_high)
    else $error("critical alert active below limit");

  a_idle_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == temp_sensor_pkg::ST_IDLE [*2] |-> !sda_oe)
    else $error("data line held while idle");

endmodule : temp_sensor_i2c

// ==== rtl/temp_sensor_pkg.sv ====
/*
 * Constants for the two-wire temperature sensor slave: bus address,
 * register pointer values, limit reset values and bit counts.
 * Assumes a single system clock domain and no other package.
 */
package temp_sensor_pkg;

  // ----------------------------------------------------------------
  // Bus addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h4b;
  localparam int ADDR_BITS = 7;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ----------------------------------------------------------------
  // Register pointer values
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_TEMP_MSB = 8'h00;
  localparam logic [7:0] PTR_TEMP_LSB = 8'h01;
  localparam logic [7:0] PTR_HIGH_MSB = 8'h04;
  localparam logic [7:0] PTR_HIGH_LSB = 8'h05;
  localparam logic [7:0] PTR_LOW_MSB = 8'h06;
  localparam logic [7:0] PTR_LOW_LSB = 8'h07;
  localparam logic [7:0] PTR_CRIT_MSB = 8'h08;
  localparam logic [7:0] PTR_CRIT_LSB = 8'h09;
  localparam logic [7:0] PTR_RESET = PTR_TEMP_MSB;

  // ----------------------------------------------------------------
  // Limit reset values (plain defaults)
  // ----------------------------------------------------------------
  localparam logic [15:0] HIGH_LIMIT_RESET = 16'h2800;
  localparam logic [15:0] LOW_LIMIT_RESET = 16'h0500;
  localparam logic [15:0] CRIT_LIMIT_RESET = 16'h4980;

  // ----------------------------------------------------------------
  // Transfer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WRITE = 3'b011,
    ST_WRITE_ACK = 3'b100,
    ST_READ = 3'b101,
    ST_READ_ACK = 3'b110
  } xfer_state_t;

endpackage : temp_sensor_pkg

// ==== rtl/i2c_line_sync.sv ====
/*
 * Synchronises the serial clock and data pins into sys_clk and reports
 * clock edges and start and stop conditions as one-cycle pulses.
 * Assumes the pins may change at any time relative to sys_clk.
 */
`timescale 1ns/1ps
module i2c_line_sync (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det,
  output logic sda_level
);

  // ----------------------------------------------------------------
  // Two-stage synchronisers, then one stage of history
  // ----------------------------------------------------------------
  logic [1:0] scl_meta_q, scl_meta_d;
  logic [1:0] sda_meta_q, sda_meta_d;
  logic scl_prev_q, scl_prev_d;
  logic sda_prev_q, sda_prev_d;

  // Shift pins through the synchronisers
  always_comb begin
    scl_meta_d = {scl_meta_q[0], scl_in};
    sda_meta_d = {sda_meta_q[0], sda_in};
    scl_prev_d = scl_meta_q[1];
    sda_prev_d = sda_meta_q[1];
  end

  // Idle bus is high on both lines
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_meta_q <= 2'h3;
      sda_meta_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_meta_q <= scl_meta_d;
      sda_meta_q <= sda_meta_d;
      scl_prev_q <= scl_prev_d;
      sda_prev_q <= sda_prev_d;
    end
  end

  // Edge and condition detection on synchronised levels only
  assign scl_rise = scl_meta_q[1] & ~scl_prev_q;
  assign scl_fall = ~scl_meta_q[1] & scl_prev_q;
  assign start_det = scl_meta_q[1] & scl_prev_q & ~sda_meta_q[1] & sda_prev_q;
  assign stop_det = scl_meta_q[1] & scl_prev_q & sda_meta_q[1] & ~sda_prev_q;
  assign sda_level = sda_meta_q[1];

endmodule : i2c_line_sync

// ==== tb/i2c_master_model.sv ====
/*
 * Behavioural two-wire bus master that talks to the sensor slave.
 * Assumes sda is the resolved wire level and that the caller keeps
 * transactions whole; SCL is 8 sys_clk per bit and stands high when idle.
 */
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic sys_clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Bus released at time zero
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Waits n clocks, then steps just past the edge
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : w

  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    w(2); sda_low = 1'b0; w(2); scl = 1'b1; w(4); sda_low = 1'b1; w(4); scl = 1'b0;
  endtask : start

  // Stop: SDA rises while SCL is high
  task automatic stop();
    w(2); sda_low = 1'b1; w(2); scl = 1'b1; w(4); sda_low = 1'b0; w(4);
  endtask : stop

  // One bit: data set mid-low, sampled mid-high
  task automatic one_bit(input logic b, output logic s);
    w(2); sda_low = !b; w(2); scl = 1'b1; w(2); s = sda; w(2); scl = 1'b0;
  endtask : one_bit

  // Byte out, MSB first, then the slave's acknowledge
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      one_bit(d[i], s);
    end
    one_bit(1'b1, s);
    ack = !s;
  endtask : wr

  // Byte in; master acknowledges all but the last byte
  task automatic rd(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      one_bit(1'b1, d[i]);
    end
    one_bit(last, s);
  endtask : rd
endmodule : i2c_master_model

// ==== tb/i2c_temperature_sensor_access_tb_top.sv ====
/*
 * Self-checking bench for temp_sensor_i2c driven by the master model.
 * Assumes pull-ups on SDA and both alert pins, so a pin reads !oe.
 */
`timescale 1ns/1ps
module i2c_temperature_sensor_access_tb_top;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] temp_word = 16'h0c80;
  logic range_pol = 1'b1;
  logic crit_pol = 1'b1;
  logic scl, sda_low, sda_oe, r_oe, c_oe;
  logic sda_o, r_o, c_o;
  logic a;
  logic [15:0] v;
  int num_errors = 0;
  int num_checks = 0;
  wire sda_wire = !(sda_low | sda_oe);

  // Clock of 20 ns
  initial forever #10 sys_clk = ~sys_clk;

  i2c_master_model m (.sys_clk(sys_clk), .scl(scl), .sda_low(sda_low), .sda(sda_wire));

  temp_sensor_i2c dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_o), .sda_oe(sda_oe), .temp_word(temp_word),
    .range_active_high(range_pol), .crit_active_high(crit_pol),
    .range_alert_out(r_o), .range_alert_oe(r_oe),
    .critical_alert_out(c_o), .critical_alert_oe(c_oe)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  // Pointer write, optionally closed by a stop
  task automatic set_ptr(input logic [7:0] p, input logic close);
    m.start();
    m.wr(8'h96, a); check("addr_ack", 16'(a), 16'h0001);
    m.wr(p, a); check("ptr_ack", 16'(a), 16'h0001);
    if (close) begin
      m.stop();
    end
  endtask : set_ptr

  // Two-byte read with fresh or repeated start
  task automatic rd16(output logic [15:0] r);
    m.start();
    m.wr(8'h97, a); check("rd_ack", 16'(a), 16'h0001);
    m.rd(1'b0, r[15:8]);
    m.rd(1'b1, r[7:0]);
    m.stop();
  endtask : rd16

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_quick();
    rd16(v);
    check("temp_read", v, 16'h0c80);
    check("deg_16ths", 16'($signed(v) >>> 3), 16'h0190);
  endtask : t_quick

  task automatic t_limits();
    logic [7:0] p [3] = '{8'h04, 8'h06, 8'h08};
    logic [15:0] d [3] = '{16'h1900, 16'h0480, 16'h2000};
    for (int i = 0; i < 3; i++) begin
      set_ptr(p[i], 1'b0);
      m.wr(d[i][15:8], a); check("msb_ack", 16'(a), 16'h0001);
      m.wr(d[i][7:0], a); check("lsb_ack", 16'(a), 16'h0001);
      m.stop();
      set_ptr(p[i], 1'b0);
      rd16(v);
      check("limit_rb", v, d[i]);
    end
  endtask : t_limits

  task automatic t_clear();
    set_ptr(8'h06, 1'b1);
    rd16(v);
    check("ptr_clear", v, temp_word);
  endtask : t_clear

  task automatic t_foreign();
    m.start();
    m.wr(8'h94, a); check("foreign", 16'(a), 16'h0000);
    m.stop();
    check("od_levels", 16'({sda_o, r_o, c_o}), 16'h0000);
  endtask : t_foreign

  // Mid-run reset with an out-of-window temperature: alert pins stay inactive
  task automatic t_reset();
    @(posedge sys_clk);
    #1;
    reset_n = 1'b0;
    temp_word = 16'h2100;
    repeat (2) @(posedge sys_clk);
    #1;
    check("rst_range", 16'(!r_oe), 16'(!range_pol));
    check("rst_crit", 16'(!c_oe), 16'(!crit_pol));
    temp_word = 16'h0c80;
    @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    repeat (5) @(posedge sys_clk);
  endtask : t_reset

  // Alert pins against limits 0x1900, 0x0480, 0x2000 in both polarities
  task automatic t_alert();
    logic [15:0] t [6] = '{16'h0c80, 16'h1a00, 16'h2100, 16'hfff0, 16'h1900, 16'h0480};
    logic re, ce;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 6; i++) begin
        @(posedge sys_clk); #1;
        temp_word = t[i];
        range_pol = p[0];
        crit_pol = !p[0];
        re = ($signed(t[i]) > $signed(16'h1900)) || ($signed(t[i]) < $signed(16'h0480));
        ce = $signed(t[i]) > $signed(16'h2000);
        repeat (3) @(posedge sys_clk);
        #1;
        check("range_pin", 16'(!r_oe), 16'(re ? range_pol : !range_pol));
        check("crit_pin", 16'(!c_oe), 16'(ce ? crit_pol : !crit_pol));
      end
    end
  endtask : t_alert

  // ----------------------------------------------------------------
  // Verdict and sequencing
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // Watchdog far beyond the few thousand clocks the scenarios need
  initial begin
    #1ms;
    num_errors++;
    results();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    repeat (5) @(posedge sys_clk);
    t_quick();
    t_limits();
    t_clear();
    t_foreign();
    t_alert();
    t_reset();
    t_quick();
    results();
  end
endmodule : i2c_temperature_sensor_access_tb_top
